// File: core/ops_pkg.sv
// Purpose: Shared constants and types for the operator panel input scanner
// Assumes: 100 MHz core_clk, Avalon-MM register access with waitrequest
// Notes:   Register offsets are byte addresses of 32-bit words
// What this block does
// - Decimal entry samples ten key lines, one per decimal digit.
// - Decimal entry shifts digits into binary value, single word limit 9,999.
// - Double word decimal entry spans two words, overflow above 99,999,999.
// - Each decimal key drives its own flag, same order as inputs.
// - Decimal key flag stays set until a different key is pressed.
// - Key detected output while any key held; earliest pressed key wins.
// - Drive off keeps stored value and clears key and function flags.
// - Hex keypad uses four return lines and four row scan outputs.
// - Hex keypad digit presses accumulate, single word limit 9,999 (65,535 with mode bit set) with overflow.
// - Double word hex keypad value stays within 0 to 99999999 with mode bit clear, full 32 bits with it set.
// - Completion flag rises after one full pass of four scan outputs.
// - Function key A to F latches own flag, clears previous one.
// - Letter detect flag while A to F held, digit detect while 0 to 9.
// - Mode bit set enters hex digits 0 to F, clear makes function keys.
// - Keypad key is accepted only after eight scan cycles since the press.
// - Thumbwheel reader handles one or two groups of four BCD digits.
// - While enabled, four strobes assert in turn, 100 ms each, repeating.
// - Group one on four inputs; group two on next four, stored if two.
// - Thumbwheel sets completion flag after each full strobe cycle.
package ops_pkg;

	// Clock and timing
	localparam int CLK_MHZ        = 100;
	localparam int SCAN_TIME_US   = 10;
	localparam int SCAN_CYC       = SCAN_TIME_US * CLK_MHZ;
	localparam int STROBE_TIME_MS = 100;
	localparam int STROBE_CYC     = STROBE_TIME_MS * 1000 * CLK_MHZ;
	localparam int KEY_SETTLE     = 8;

	// Widths and counts
	localparam int VAL_W     = 32;
	localparam int DEC_KEYS  = 10;
	localparam int HEX_LINES = 4;
	localparam int TW_LINES  = 8;
	localparam int FN_KEYS   = 6;

	// Entry limits and radix
	localparam logic [31:0] LIM_DEC_1W = 32'h0000270f;
	localparam logic [31:0] LIM_DEC_2W = 32'h05f5e0ff;
	localparam logic [31:0] LIM_HEX_1W = 32'h0000ffff;
	localparam logic [31:0] LIM_HEX_2W = 32'hffffffff;
	localparam logic [3:0]  DEC_RADIX  = 4'ha;
	localparam logic [3:0]  BCD_MAX    = 4'h9;

	// Register offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_DEC_VAL  = 8'h04;
	localparam logic [7:0] REG_HEX_VAL  = 8'h08;
	localparam logic [7:0] REG_TW_VAL0  = 8'h0c;
	localparam logic [7:0] REG_TW_VAL1  = 8'h10;
	localparam logic [7:0] REG_DEC_STAT = 8'h14;
	localparam logic [7:0] REG_HEX_STAT = 8'h18;
	localparam logic [7:0] REG_TW_STAT  = 8'h1c;

	// Status field positions
	localparam int DST_DET  = 16;
	localparam int DST_OVF  = 17;
	localparam int HST_LET  = 8;
	localparam int HST_DIG  = 9;
	localparam int HST_OVF  = 10;
	localparam int HST_DONE = 11;
	localparam int TST_DONE = 0;
	localparam int TST_ERR  = 1;

	// Control register, bit 0 is dec_en
	typedef struct packed {
		logic clr_vals;
		logic tw_two;
		logic hex_dbl;
		logic dec_dbl;
		logic hex_entry_select;
		logic tw_en;
		logic hex_en;
		logic dec_en;
	} ops_ctrl_t;

	localparam ops_ctrl_t CTRL_RST = 8'h00;

	// Hex keypad flag group
	typedef struct packed {
		logic [FN_KEYS-1:0] fn;
		logic               letter_det;
		logic               digit_det;
	} ops_hex_flags_t;

	// Register bus states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} ops_bus_st_t;

endpackage

// File: core/ops_sync2.sv
// Purpose: Two flip-flop synchroniser for panel pin inputs
// Assumes: Inputs are slow switch contacts
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module ops_sync2 #(parameter int W = 1)
(
	input  wire logic         core_clk, // Core clock
	input  wire logic         resetn,   // Async reset, active low
	input  wire logic [W-1:0] async_in, // Pin levels
	output logic      [W-1:0] sync_out  // Synchronised levels
);

	logic [W-1:0] meta_q;

	// Two stage capture
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// File: core/ops_accum.sv
// Purpose: Shift one digit into a stored value with limit check
// Assumes: Digit below radix
// Notes:   On overflow the old value is passed through unchanged
`timescale 1ns/1ns
module ops_accum import ops_pkg::*; #(parameter int W = VAL_W)
(
	input  wire logic [W-1:0] acc_in,  // Current value
	input  wire logic [3:0]   digit,   // New digit
	input  wire logic         hex,     // Radix 16 when set, else 10
	input  wire logic         dbl,     // Two word limit
	output logic      [W-1:0] acc_out, // Updated value
	output logic              ovf      // Limit exceeded
);

	logic [W+4:0] sum;
	logic [W+4:0] limit;

	// Multiply, add, compare
	always_comb
	begin
		if (hex)
		begin
			sum   = (W+5)'({acc_in, 4'h0}) + (W+5)'(digit);
			limit = (W+5)'(dbl ? LIM_HEX_2W : LIM_HEX_1W);
		end
		else
		begin
			sum   = (W+5)'(acc_in) * (W+5)'(DEC_RADIX) + (W+5)'(digit);
			limit = (W+5)'(dbl ? LIM_DEC_2W : LIM_DEC_1W);
		end
		ovf     = sum > limit;
		acc_out = ovf ? acc_in : sum[W-1:0];
	end

endmodule

// File: core/ops_panel_scanner.sv
// Purpose: Operator panel input scanner: decimal keys, hex keypad, thumbwheels
// Assumes: Pins are raw contacts, active high; Avalon-MM slave, 32-bit words
// Notes:   Flags are registered; done_flag is a one-cycle pulse
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module ops_panel_scanner import ops_pkg::*;
#(
	parameter int SCAN_CYC_P   = SCAN_CYC,
	parameter int STROBE_CYC_P = STROBE_CYC,
	parameter int SETTLE_P     = KEY_SETTLE
)
(
	input  wire logic                 core_clk,       // 100 MHz clock
	input  wire logic                 resetn,         // Async reset, active low
	input  wire logic [7:0]           avs_address,    // Byte address
	input  wire logic                 avs_read,       // Read request
	input  wire logic                 avs_write,      // Write request
	input  wire logic [31:0]          avs_writedata,  // Write data
	input  wire logic [3:0]           avs_byteenable, // Byte lanes
	output logic      [31:0]          avs_readdata,   // Read data
	output logic                      avs_waitrequest, // Stall
	input  wire logic [DEC_KEYS-1:0]  dec_keys,       // Decimal key pins
	input  wire logic [HEX_LINES-1:0] hex_ret,        // Keypad return pins
	output logic      [HEX_LINES-1:0] hex_scan,       // Keypad row scan
	input  wire logic [TW_LINES-1:0]  tw_in,          // Thumbwheel data pins
	output logic      [3:0]           tw_strobe,      // Thumbwheel strobes
	output logic      [DEC_KEYS-1:0]  dec_key_flag,   // Latched decimal flags
	output logic                      dec_key_det,    // Decimal key held
	output ops_hex_flags_t            hex_flags,      // Keypad flags
	output logic                      done_flag       // Completion pulse
);

	localparam int SCW = $clog2(SCAN_CYC_P);
	localparam int STW = $clog2(STROBE_CYC_P);

	logic [DEC_KEYS-1:0]  dec_s;
	logic [HEX_LINES-1:0] ret_s;
	logic [TW_LINES-1:0]  tw_s;

	// Pin synchronisers
	ops_sync2 #(.W(DEC_KEYS + HEX_LINES + TW_LINES)) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.async_in ({tw_in, hex_ret, dec_keys}),
		.sync_out ({tw_s, ret_s, dec_s})
	);

	// State
	ops_bus_st_t          bus_q, bus_d;
	logic [31:0]          rdata_q, rdata_d;
	ops_ctrl_t            ctrl_q, ctrl_d;
	logic [SCW-1:0]       scnt_q, scnt_d;
	logic                 tick;
	logic [VAL_W-1:0]     dval_q, dval_d;
	logic [DEC_KEYS-1:0]  dflag_q, dflag_d;
	logic                 ddet_q, ddet_d, dheld_q, dheld_d, dovf_q, dovf_d;
	logic [3:0]           didx_q, didx_d;
	logic [1:0]           row_q, row_d;
	logic [HEX_LINES-1:0] scan_q, scan_d;
	logic [15:0]          map_q, map_d;
	logic [3:0]           cand_q, cand_d, settle_q, settle_d;
	logic                 cv_q, cv_d, taken_q, taken_d;
	logic [VAL_W-1:0]     hval_q, hval_d;
	ops_hex_flags_t       hfl_q, hfl_d;
	logic                 hovf_q, hovf_d, hdone_q, hdone_d;
	logic [STW-1:0]       stc_q, stc_d;
	logic [1:0]           sidx_q, sidx_d;
	logic [3:0]           strb_q, strb_d;
	logic [VAL_W-1:0]     tacc0_q, tacc0_d, tacc1_q, tacc1_d;
	logic [VAL_W-1:0]     tval0_q, tval0_d, tval1_q, tval1_d;
	logic                 terr_q, terr_d, tdone_q, tdone_d, done_q, done_d;

	// Combinational helpers
	logic             bus_req, wr_now, dpick_v, hpick_v, pass_end, step_end;
	logic [3:0]       dpick, hpick, hdig;
	logic [15:0]      map_full;
	logic [VAL_W-1:0] dacc, hacc, tacc0, tacc1, tin0, tin1;
	logic             dovf, hovf, hhex;

	// Bus handshake: answer one cycle after the request is seen
	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & (bus_q == BUS_IDLE);
	assign wr_now          = avs_write & (bus_q == BUS_ACK);
	assign avs_readdata    = rdata_q;

	// Digit accumulators
	ops_accum #(.W(VAL_W)) u_dec_acc (
		.acc_in  (dval_q),
		.digit   (dpick),
		.hex     (1'b0),
		.dbl     (ctrl_q.dec_dbl),
		.acc_out (dacc),
		.ovf     (dovf)
	);
	ops_accum #(.W(VAL_W)) u_hex_acc (
		.acc_in  (hval_q),
		.digit   (cand_q),
		.hex     (hhex),
		.dbl     (ctrl_q.hex_dbl),
		.acc_out (hacc),
		.ovf     (hovf)
	);
	ops_accum #(.W(VAL_W)) u_tw0_acc (
		.acc_in  (tin0),
		.digit   (tw_s[3:0]),
		.hex     (1'b0),
		.dbl     (1'b1),
		.acc_out (tacc0),
		.ovf     ()
	);
	ops_accum #(.W(VAL_W)) u_tw1_acc (
		.acc_in  (tin1),
		.digit   (tw_s[7:4]),
		.hex     (1'b0),
		.dbl     (1'b1),
		.acc_out (tacc1),
		.ovf     ()
	);

	assign hhex = ctrl_q.hex_entry_select;
	assign tin0 = (sidx_q == 2'd0) ? '0 : tacc0_q;
	assign tin1 = (sidx_q == 2'd0) ? '0 : tacc1_q;
	assign hdig = cand_q;

	// Lowest set index wins among simultaneous presses
	always_comb
	begin
		dpick   = 4'h0;
		dpick_v = 1'b0;
		for (int i = DEC_KEYS - 1; i >= 0; i--)
		begin
			if (dec_s[i])
			begin
				dpick   = 4'(i);
				dpick_v = 1'b1;
			end
		end
		map_full = map_q;
		map_full[{row_q, 2'b00} +: HEX_LINES] = ret_s;
		hpick   = 4'h0;
		hpick_v = 1'b0;
		for (int k = 15; k >= 0; k--)
		begin
			if (map_full[k])
			begin
				hpick   = 4'(k);
				hpick_v = 1'b1;
			end
		end
	end

	// Scan tick divider
	always_comb
	begin
		tick   = (scnt_q == SCW'(SCAN_CYC_P - 1));
		scnt_d = tick ? '0 : scnt_q + 1'b1;
	end

	// Register bus and control
	always_comb
	begin
		bus_d   = bus_q;
		rdata_d = rdata_q;
		ctrl_d  = ctrl_q;
		ctrl_d.clr_vals = 1'b0;
		unique case (bus_q)
			BUS_IDLE:
			begin
				if (bus_req)
					bus_d = BUS_ACK;
				if (avs_read)
				begin
					unique case (avs_address)
						REG_CTRL:     rdata_d = {24'h0, ctrl_q};
						REG_DEC_VAL:  rdata_d = dval_q;
						REG_HEX_VAL:  rdata_d = hval_q;
						REG_TW_VAL0:  rdata_d = tval0_q;
						REG_TW_VAL1:  rdata_d = tval1_q;
						REG_DEC_STAT: rdata_d = {14'h0, dovf_q, ddet_q, 6'h0, dflag_q};
						REG_HEX_STAT: rdata_d = {20'h0, hdone_q, hovf_q, hfl_q.digit_det,
							hfl_q.letter_det, 2'h0, hfl_q.fn};
						REG_TW_STAT:  rdata_d = {30'h0, terr_q, tdone_q};
						default:      rdata_d = 32'h0;
					endcase
				end
			end
			BUS_ACK:
			begin
				bus_d = BUS_IDLE;
				if (wr_now && avs_address == REG_CTRL && avs_byteenable[0])
					ctrl_d = ops_ctrl_t'(avs_writedata[7:0]);
			end
		endcase
	end

	// Decimal key entry
	always_comb
	begin
		dval_d  = dval_q;
		dflag_d = dflag_q;
		ddet_d  = ddet_q;
		dheld_d = dheld_q;
		didx_d  = didx_q;
		dovf_d  = dovf_q;
		if (wr_now && avs_address == REG_DEC_STAT && avs_byteenable[2]
			&& avs_writedata[DST_OVF])
			dovf_d = 1'b0;
		if (!ctrl_q.dec_en)
		begin
			dflag_d = '0;
			ddet_d  = 1'b0;
			dheld_d = 1'b0;
		end
		else if (tick)
		begin
			ddet_d = |dec_s;
			if (dheld_q && !dec_s[didx_q])
				dheld_d = 1'b0;
			else if (!dheld_q && dpick_v)
			begin
				dheld_d = 1'b1;
				didx_d  = dpick;
				dflag_d = DEC_KEYS'(1) << dpick;
				if (dovf)
					dovf_d = 1'b1;
				else
					dval_d = dacc;
			end
		end
		if (ctrl_q.clr_vals)
			dval_d = '0;
	end

	// Hex keypad scanner
	always_comb
	begin
		row_d    = row_q;
		scan_d   = scan_q;
		map_d    = map_q;
		cand_d   = cand_q;
		cv_d     = cv_q;
		taken_d  = taken_q;
		settle_d = settle_q;
		hval_d   = hval_q;
		hfl_d    = hfl_q;
		hovf_d   = hovf_q;
		hdone_d  = hdone_q;
		pass_end = 1'b0;
		if (wr_now && avs_address == REG_HEX_STAT && avs_byteenable[1])
		begin
			if (avs_writedata[HST_OVF])
				hovf_d = 1'b0;
			if (avs_writedata[HST_DONE])
				hdone_d = 1'b0;
		end
		if (!ctrl_q.hex_en)
		begin
			hfl_d  = '0;
			row_d  = 2'd0;
			scan_d = '0;
			map_d  = '0;
			cv_d   = 1'b0;
		end
		else
		begin
			scan_d = HEX_LINES'(1) << row_q;
			if (tick)
			begin
				row_d = row_q + 2'd1;
				map_d = map_full;
				if (cv_q && !taken_q && settle_q < 4'(SETTLE_P))
					settle_d = settle_q + 4'd1;
				if (row_q == 2'd3)
				begin
					pass_end         = 1'b1;
					hdone_d          = 1'b1;
					map_d            = '0;
					hfl_d.letter_det = |map_full[15:10];
					hfl_d.digit_det  = |map_full[9:0];
					if (cv_q && map_full[cand_q])
					begin
						if (!taken_q && settle_q >= 4'(SETTLE_P))
						begin
							taken_d = 1'b1;
							if (hhex || hdig < DEC_RADIX)
							begin
								if (hovf)
									hovf_d = 1'b1;
								else
									hval_d = hacc;
							end
							else
								hfl_d.fn = FN_KEYS'(1) << (hdig - DEC_RADIX);
						end
					end
					else
					begin
						cv_d     = hpick_v;
						cand_d   = hpick;
						taken_d  = 1'b0;
						settle_d = 4'd0;
					end
				end
			end
		end
		if (ctrl_q.clr_vals)
			hval_d = '0;
	end

	// Thumbwheel reader
	always_comb
	begin
		stc_d    = stc_q;
		sidx_d   = sidx_q;
		strb_d   = strb_q;
		tacc0_d  = tacc0_q;
		tacc1_d  = tacc1_q;
		tval0_d  = tval0_q;
		tval1_d  = tval1_q;
		terr_d   = terr_q;
		tdone_d  = tdone_q;
		step_end = 1'b0;
		if (wr_now && avs_address == REG_TW_STAT && avs_byteenable[0])
		begin
			if (avs_writedata[TST_DONE])
				tdone_d = 1'b0;
			if (avs_writedata[TST_ERR])
				terr_d = 1'b0;
		end
		if (!ctrl_q.tw_en)
		begin
			stc_d  = '0;
			sidx_d = 2'd0;
			strb_d = '0;
		end
		else
		begin
			strb_d = 4'h1 << sidx_q;
			stc_d  = stc_q + 1'b1;
			if (stc_q == STW'(STROBE_CYC_P - 1))
			begin
				stc_d   = '0;
				sidx_d  = sidx_q + 2'd1;
				tacc0_d = tacc0;
				tacc1_d = tacc1;
				if (tw_s[3:0] > BCD_MAX || (ctrl_q.tw_two && tw_s[7:4] > BCD_MAX))
					terr_d = 1'b1;
				if (sidx_q == 2'd3)
				begin
					step_end = 1'b1;
					tdone_d  = 1'b1;
					tval0_d  = tacc0;
					if (ctrl_q.tw_two)
						tval1_d = tacc1;
				end
			end
		end
		if (ctrl_q.clr_vals)
		begin
			tval0_d = '0;
			tval1_d = '0;
		end
		done_d = pass_end | step_end;
	end

	// Registers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bus_q    <= BUS_IDLE;
			rdata_q  <= '0;
			ctrl_q   <= CTRL_RST;
			scnt_q   <= '0;
			dval_q   <= '0;
			dflag_q  <= '0;
			ddet_q   <= 1'b0;
			dheld_q  <= 1'b0;
			didx_q   <= '0;
			dovf_q   <= 1'b0;
			row_q    <= '0;
			scan_q   <= '0;
			map_q    <= '0;
			cand_q   <= '0;
			cv_q     <= 1'b0;
			taken_q  <= 1'b0;
			settle_q <= '0;
			hval_q   <= '0;
			hfl_q    <= '0;
			hovf_q   <= 1'b0;
			hdone_q  <= 1'b0;
			stc_q    <= '0;
			sidx_q   <= '0;
			strb_q   <= '0;
			tacc0_q  <= '0;
			tacc1_q  <= '0;
			tval0_q  <= '0;
			tval1_q  <= '0;
			terr_q   <= 1'b0;
			tdone_q  <= 1'b0;
			done_q   <= 1'b0;
		end
		else
		begin
			bus_q    <= bus_d;
			rdata_q  <= rdata_d;
			ctrl_q   <= ctrl_d;
			scnt_q   <= scnt_d;
			dval_q   <= dval_d;
			dflag_q  <= dflag_d;
			ddet_q   <= ddet_d;
			dheld_q  <= dheld_d;
			didx_q   <= didx_d;
			dovf_q   <= dovf_d;
			row_q    <= row_d;
			scan_q   <= scan_d;
			map_q    <= map_d;
			cand_q   <= cand_d;
			cv_q     <= cv_d;
			taken_q  <= taken_d;
			settle_q <= settle_d;
			hval_q   <= hval_d;
			hfl_q    <= hfl_d;
			hovf_q   <= hovf_d;
			hdone_q  <= hdone_d;
			stc_q    <= stc_d;
			sidx_q   <= sidx_d;
			strb_q   <= strb_d;
			tacc0_q  <= tacc0_d;
			tacc1_q  <= tacc1_d;
			tval0_q  <= tval0_d;
			tval1_q  <= tval1_d;
			terr_q   <= terr_d;
			tdone_q  <= tdone_d;
			done_q   <= done_d;
		end
	end

	// Output drive
	assign hex_scan     = scan_q;
	assign tw_strobe    = strb_q;
	assign dec_key_flag = dflag_q;
	assign dec_key_det  = ddet_q;
	assign hex_flags    = hfl_q;
	assign done_flag    = done_q;

endmodule

// File: testbench/ops_scan_asserts.sv
// Purpose: Port-level assertions for the panel scanner
// Assumes: Bound to ops_panel_scanner, one clock domain
// Notes:   Step counters measure how long a row or strobe stands
`timescale 1ns/1ns
module ops_scan_asserts import ops_pkg::*;
#(
	parameter int SCAN_CYC_P   = SCAN_CYC,
	parameter int STROBE_CYC_P = STROBE_CYC
)
(
	input wire logic                core_clk,     // Clock
	input wire logic                resetn,       // Async reset, active low
	input wire logic [3:0]          hex_scan,     // Row scan
	input wire logic [3:0]          tw_strobe,    // Strobes
	input wire logic [DEC_KEYS-1:0] dec_key_flag, // Decimal flags
	input wire logic                dec_key_det,  // Decimal key held
	input wire ops_hex_flags_t      hex_flags,    // Keypad flags
	input wire logic                done_flag     // Completion pulse
);
	logic [3:0]  row_q;  // Previous row
	logic [3:0]  stb_q;  // Previous strobe
	logic [31:0] rcnt_q; // Cycles the row has stood
	logic [31:0] rcnt_d;
	logic [31:0] scnt_q; // Cycles the strobe has stood
	logic [31:0] scnt_d;

	// Restart a count whenever the watched output moves
	always_comb
	begin
		rcnt_d = (hex_scan != row_q) ? 32'h1 : rcnt_q + 32'h1;
		scnt_d = (tw_strobe != stb_q) ? 32'h1 : scnt_q + 32'h1;
	end

	// Register previous values and counts
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			row_q  <= 4'h0;
			stb_q  <= 4'h0;
			rcnt_q <= 32'h0;
			scnt_q <= 32'h0;
		end
		else
		begin
			row_q  <= hex_scan;
			stb_q  <= tw_strobe;
			rcnt_q <= rcnt_d;
			scnt_q <= scnt_d;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	a_scan_onehot: assert property ($onehot0(hex_scan))
		else $error("row scan not one-hot");
	a_stb_onehot: assert property ($onehot0(tw_strobe))
		else $error("strobes not one-hot");
	a_flag_onehot: assert property ($onehot0(dec_key_flag))
		else $error("decimal flags not one-hot");
	a_fn_onehot: assert property ($onehot0(hex_flags.fn))
		else $error("function flags not one-hot");
	a_scan_order: assert property ((row_q != 4'h0 && hex_scan != 4'h0 && hex_scan != row_q)
		|-> hex_scan == {row_q[2:0], row_q[3]}) else $error("row order wrong");
	a_stb_order: assert property ((stb_q != 4'h0 && tw_strobe != 4'h0 && tw_strobe != stb_q)
		|-> tw_strobe == {stb_q[2:0], stb_q[3]}) else $error("strobe order wrong");
	a_scan_len: assert property ((row_q > 4'h1 && hex_scan != 4'h0 && hex_scan != row_q)
		|-> rcnt_q == SCAN_CYC_P) else $error("row step length wrong");
	a_stb_len: assert property ((stb_q != 4'h0 && tw_strobe != 4'h0 && tw_strobe != stb_q)
		|-> scnt_q == STROBE_CYC_P) else $error("strobe step length wrong");
	a_pass_done: assert property ((row_q == 4'h8 && hex_scan == 4'h1)
		|-> $past(done_flag)) else $error("no done after keypad pass");
	a_tw_done: assert property ((stb_q == 4'h8 && tw_strobe == 4'h1)
		|-> $past(done_flag)) else $error("no done after strobe cycle");
	a_det_flag: assert property ($rose(dec_key_det) |-> $onehot(dec_key_flag))
		else $error("key held without its flag");
endmodule

// File: testbench/ops_panel_model.sv
// Purpose: Keypad matrix and thumbwheel switches on the panel pins
// Assumes: Lines not selected are held low by pull-downs
// Notes:   Bench picks the held key and the dialled digits
`timescale 1ns/1ns
module ops_panel_model import ops_pkg::*;
(
	input  wire logic [3:0]  hex_scan,  // Row drive
	input  wire logic [3:0]  tw_strobe, // Strobes
	input  wire logic [3:0]  key_code,  // Held key, row*4+column
	input  wire logic        key_down,  // A key is held
	input  wire logic [31:0] tw_val,    // Dialled BCD, group two high
	output logic      [3:0]  hex_ret,   // Column returns
	output logic      [7:0]  tw_in      // Switch data lines
);
	// Held key closes its row onto its column
	always_comb
	begin
		hex_ret = 4'h0;
		if (key_down && hex_scan[key_code[3:2]])
			hex_ret = 4'h1 << key_code[1:0];
	end

	// Strobe k shows digit k of both groups, thousands first
	always_comb
	begin
		tw_in = 8'h00;
		for (int k = 0; k < 4; k++)
			if (tw_strobe[k])
				tw_in = {tw_val[31-4*k -: 4], tw_val[15-4*k -: 4]};
	end
endmodule

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the panel scanner
// Assumes: Short scan and strobe steps set by parameters
// Notes:   Register access through a held Avalon master
`timescale 1ns/1ns
module tb_top import ops_pkg::*;
;
	localparam int SCAN_P   = 8;
	localparam int STROBE_P = 16;
	logic           core_clk, resetn, avs_read, avs_write, avs_waitrequest;
	logic           dec_key_det, done_flag, key_down;
	logic [7:0]     avs_address, tw_in;
	logic [31:0]    avs_writedata, avs_readdata, tw_val;
	logic [3:0]     avs_byteenable, hex_ret, hex_scan, tw_strobe, key_code;
	logic [9:0]     dec_keys, dec_key_flag;
	ops_hex_flags_t hex_flags;
	int             fail_count, samples_checked;

	// Clock at 100 MHz
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	ops_panel_scanner #(.SCAN_CYC_P(SCAN_P), .STROBE_CYC_P(STROBE_P), .SETTLE_P(KEY_SETTLE))
		i_ops_panel_scanner (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .dec_keys(dec_keys), .hex_ret(hex_ret),
		.hex_scan(hex_scan), .tw_in(tw_in), .tw_strobe(tw_strobe), .hex_flags(hex_flags),
		.dec_key_flag(dec_key_flag), .dec_key_det(dec_key_det), .done_flag(done_flag));

	ops_panel_model i_ops_panel_model (.hex_scan(hex_scan), .tw_strobe(tw_strobe),
		.key_code(key_code), .key_down(key_down), .tw_val(tw_val), .hex_ret(hex_ret),
		.tw_in(tw_in));

	// Count a comparison, report a mismatch
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	// One access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		avs_address   <= a;
		avs_writedata <= wd;
		avs_write     <= w;
		avs_read      <= !w;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		if (n >= 50)
			chk("bus wait", 32'h0, 32'h1);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(n, x & m, e);
	endtask

	task automatic ticks(input int n);
		repeat (n * SCAN_P) @(posedge core_clk);
	endtask

	// Wait for a number of completion pulses
	task automatic wait_done(input int c);
		int n;
		repeat (c)
		begin
			n = 0;
			do
			begin
				@(posedge core_clk);
				n++;
			end
			while (done_flag !== 1'b1 && n < 200);
			if (n >= 200)
				chk("done wait", 32'h0, 32'h1);
		end
	endtask

	// Press one decimal key, then release it
	task automatic press_dec(input int k);
		dec_keys <= 10'h001 << k;
		ticks(3);
		chk("dec press", 32'({dec_key_det, dec_key_flag}), 32'h400 | 32'h1 << k);
		dec_keys <= 10'h000;
		ticks(2);
		chk("dec hold", 32'({dec_key_det, dec_key_flag}), 32'h1 << k);
	endtask

	// Hold one keypad key long enough to be taken
	task automatic press_hex(input logic [3:0] c);
		key_code <= c;
		key_down <= 1'b1;
		ticks(20);
		chk("hex det", 32'({hex_flags.letter_det, hex_flags.digit_det}), (c > 4'h9) ? 2 : 1);
		key_down <= 1'b0;
		ticks(8);
	endtask

	task automatic t_reset;
		for (int a = 0; a <= 32; a += 4)
			rd("reg reset", 8'(a), 32'hffffffff, 32'h0);
		chk("out reset", 32'({hex_scan, tw_strobe, done_flag, dec_key_flag}), 32'h0);
		$display("test reset done");
	endtask

	task automatic t_dec;
		wr(REG_CTRL, 32'h81);
		for (int k = 1; k <= 4; k++)
			press_dec(k);
		press_dec(5);
		rd("dec value", REG_DEC_VAL, 32'hffffffff, 32'h4d2);
		rd("dec stat", REG_DEC_STAT, 32'hffffffff, 32'h20020);
		dec_keys <= 10'h080;
		ticks(2);
		dec_keys <= 10'h088;
		ticks(2);
		chk("dec first", 32'(dec_key_flag), 32'h80);
		dec_keys <= 10'h000;
		ticks(2);
		wr(REG_CTRL, 32'h0);
		ticks(1);
		chk("dec off", 32'({dec_key_det, dec_key_flag}), 32'h0);
		rd("dec keep", REG_DEC_VAL, 32'hffffffff, 32'h4d2);
		wr(REG_DEC_STAT, 32'h20000);
		wr(REG_CTRL, 32'h91);
		for (int k = 0; k < 9; k++)
			press_dec(9);
		rd("dec dbl", REG_DEC_VAL, 32'hffffffff, LIM_DEC_2W);
		rd("dec dbl ovf", REG_DEC_STAT, 32'hffffffff, 32'h20200);
		$display("test decimal done");
	endtask

	task automatic t_hex;
		wr(REG_CTRL, 32'h8a);
		key_code <= 4'ha;
		key_down <= 1'b1;
		ticks(6);
		rd("hex early", REG_HEX_VAL, 32'hffffffff, 32'h0);
		ticks(14);
		key_down <= 1'b0;
		ticks(8);
		rd("hex a", REG_HEX_VAL, 32'hffffffff, 32'ha);
		press_hex(4'h5);
		rd("hex a5", REG_HEX_VAL, 32'hffffffff, 32'ha5);
		wr(REG_CTRL, 32'h82);
		press_hex(4'ha);
		chk("fn a", 32'(hex_flags.fn), 32'h01);
		press_hex(4'hd);
		chk("fn d", 32'(hex_flags.fn), 32'h08);
		press_hex(4'h7);
		for (int k = 0; k < 4; k++)
			press_hex(4'h9);
		rd("hex val", REG_HEX_VAL, 32'hffffffff, 32'h1f3f);
		rd("hex ovf", REG_HEX_STAT, 32'h400, 32'h400);
		wr(REG_CTRL, 32'h0);
		ticks(1);
		chk("hex off", 32'(hex_flags), 32'h0);
		rd("hex keep", REG_HEX_VAL, 32'hffffffff, 32'h1f3f);
		wr(REG_CTRL, 32'ha2);
		for (int k = 0; k < 5; k++)
			press_hex(4'h9);
		rd("hex dbl", REG_HEX_VAL, 32'hffffffff, 32'h1869f);
		wr(REG_CTRL, 32'h0);
		$display("test keypad done");
	endtask

	task automatic t_tw;
		tw_val <= 32'h56781234;
		wr(REG_CTRL, 32'hc4);
		wait_done(2);
		rd("tw grp1", REG_TW_VAL0, 32'hffffffff, 32'h4d2);
		rd("tw grp2", REG_TW_VAL1, 32'hffffffff, 32'h162e);
		rd("tw done", REG_TW_STAT, 32'h1, 32'h1);
		wr(REG_CTRL, 32'h84);
		wait_done(2);
		rd("tw one", REG_TW_VAL1, 32'hffffffff, 32'h0);
		rd("tw keep", REG_TW_VAL0, 32'hffffffff, 32'h4d2);
		wr(REG_TW_STAT, 32'h3);
		tw_val <= 32'h000012a4;
		wait_done(2);
		rd("tw err", REG_TW_STAT, 32'h2, 32'h2);
		wr(REG_CTRL, 32'h0);
		$display("test thumbwheel done");
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		fail_count      = 0;
		samples_checked = 0;
		resetn          = 1'b0;
		{avs_read, avs_write, key_down} = 3'h0;
		avs_address     = 8'h00;
		avs_writedata   = 32'h0;
		avs_byteenable  = 4'hf;
		dec_keys        = 10'h000;
		key_code        = 4'h0;
		tw_val          = 32'h0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_reset;
		t_dec;
		t_hex;
		t_tw;
		close_out;
	end

	// Watchdog against a hang
	initial
	begin
		repeat (30000) @(posedge core_clk);
		fail_count++;
		close_out;
	end
endmodule

bind ops_panel_scanner ops_scan_asserts #(.SCAN_CYC_P(SCAN_CYC_P), .STROBE_CYC_P(STROBE_CYC_P))
	i_ops_scan_asserts (.core_clk(core_clk), .resetn(resetn), .hex_scan(hex_scan),
	.tw_strobe(tw_strobe), .dec_key_flag(dec_key_flag), .dec_key_det(dec_key_det),
	.hex_flags(hex_flags), .done_flag(done_flag));
